// [hw/hsp_pin_ctl.sv]
`timescale 1ns/1ps
// What this block does
// RULE1: latch straps at power-on and reset release
// RULE2: power pin high means port on
// RULE3: released power pin reads overcurrent
// RULE4: rom select low only during rom access
// RULE5: clock pin: rom clock or open-drain bus
// RULE6: data pin: rom data or bus data
// RULE7: data-in pin: rom data or general io
// RULE8: rom select strap sets fixed port count
// RULE9: data-in strap enables battery charging
// RULE10: chip reset held keeps device in reset
// RULE11: gang strap high: one shared power pin
// RULE12: runs from 25 MHz reference clock; the block is clocked by sys_clk and timed at SYS_CLK_MHZ = 40
// RULE13: pull-ups on clock, data pick bus mode
// RULE14: pins drive only after straps captured
module hsp_pin_ctl (
	input  wire logic                          sys_clk,
	input  wire logic                          reset_n,
	input  wire logic                          chip_reset_n,
	input  wire logic                          rom_select_n_i,
	output logic                               rom_select_n_o,
	output logic                               rom_select_n_oe,
	input  wire logic                          mgmt_bus_clock_i,
	output logic                               mgmt_bus_clock_o,
	output logic                               mgmt_bus_clock_oe,
	input  wire logic                          mgmt_bus_data_i,
	output logic                               mgmt_bus_data_o,
	output logic                               mgmt_bus_data_oe,
	input  wire logic                          rom_serial_in_i,
	output logic                               rom_serial_in_o,
	output logic                               rom_serial_in_oe,
	input  wire logic                          port1_power_ctl_oc_i,
	output logic                               port1_power_ctl_oc_o,
	output logic                               port1_power_ctl_oc_oe,
	input  wire logic                          port2_power_ctl_oc_i,
	output logic                               port2_power_ctl_oc_o,
	output logic                               port2_power_ctl_oc_oe,
	input  wire logic                          shared_power_select_i,
	output logic                               shared_power_select_o,
	output logic                               shared_power_select_oe,
	input  wire logic                          rom_access,
	input  wire logic                          rom_clk,
	input  wire logic                          rom_mosi,
	output logic                               rom_miso,
	input  wire logic                          mgmt_clock_pull_low,
	input  wire logic                          mgmt_data_pull_low,
	output logic                               mgmt_clock_in,
	output logic                               mgmt_data_in,
	input  wire logic                          general_io_a_out,
	input  wire logic                          general_io_a_en,
	output logic                               general_io_a_in,
	input  wire logic                          general_io_d_out,
	input  wire logic                          general_io_d_en,
	output logic                               general_io_d_in,
	input  wire logic [hsp_pkg::PORT_COUNT-1:0] port_power_req,
	input  wire logic [hsp_pkg::PORT_COUNT-1:0] port_oc_clear,
	output logic      [hsp_pkg::PORT_COUNT-1:0] port_overcurrent,
	output logic                               in_reset,
	output logic                               smbus_mode,
	output logic                               fixed_port_count,
	output logic                               charging_enable,
	output logic                               gang_mode
);
	localparam logic [hsp_pkg::CNT_W-1:0] SETTLE_LAST = hsp_pkg::CNT_W'(hsp_pkg::STRAP_SETTLE_CYC - 1);

	logic [hsp_pkg::SYNC_W-1:0] sync_s;
	hsp_pkg::hsp_state_t        state_q;
	hsp_pkg::hsp_state_t        state_d;
	logic [hsp_pkg::CNT_W-1:0]  settle_q;
	logic [hsp_pkg::CNT_W-1:0]  settle_d;
	logic                       smbus_mode_q;
	logic                       fixed_cnt_q;
	logic                       charge_en_q;
	logic                       gang_mode_q;

	// every pin input is synchronised before use
	hsp_sync #(
		.W (hsp_pkg::SYNC_W)
	) u_sync (
		.sys_clk  (sys_clk),
		.reset_n  (reset_n),
		.async_in ({shared_power_select_i, port2_power_ctl_oc_i, port1_power_ctl_oc_i, rom_serial_in_i,
			mgmt_bus_data_i, mgmt_bus_clock_i, rom_select_n_i, chip_reset_n}),
		.sync_out (sync_s)
	);

	wire chip_rst_n_s = sync_s[hsp_pkg::SB_CHIP_RST];
	wire rom_sel_s    = sync_s[hsp_pkg::SB_ROM_SEL];
	wire clk_s        = sync_s[hsp_pkg::SB_MGMT_CLK];
	wire dat_s        = sync_s[hsp_pkg::SB_MGMT_DAT];
	wire din_s        = sync_s[hsp_pkg::SB_ROM_DIN];
	wire gang_s       = sync_s[hsp_pkg::SB_GANG];

	// strap capture happens on the last settle cycle; settle counts in sys_clk cycles
	wire capture = (state_q == hsp_pkg::HSP_ST_SETTLE) && (settle_q == SETTLE_LAST); // [RULE12]
	wire run     = (state_q == hsp_pkg::HSP_ST_RUN);
	wire spi_run = run & ~smbus_mode_q;
	wire smb_run = run & smbus_mode_q;

	// reset sequencer: hold while chip reset is low, settle, capture, run
	always_comb
	begin
		state_d  = state_q;
		settle_d = '0;
		case (state_q)
			hsp_pkg::HSP_ST_HOLD:
				if (chip_rst_n_s)
					state_d = hsp_pkg::HSP_ST_SETTLE;
			hsp_pkg::HSP_ST_SETTLE:
			begin
				settle_d = settle_q + 1'b1;
				if (capture)
					state_d = hsp_pkg::HSP_ST_RUN;
			end
			hsp_pkg::HSP_ST_RUN:
				state_d = hsp_pkg::HSP_ST_RUN;
			default:
				state_d = hsp_pkg::HSP_ST_HOLD;
		endcase
		if (!chip_rst_n_s)
		begin
			state_d  = hsp_pkg::HSP_ST_HOLD; // [RULE10]
			settle_d = '0;
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (!reset_n)
		begin
			state_q  <= hsp_pkg::HSP_ST_HOLD;
			settle_q <= '0;
			in_reset <= 1'b1;
		end
		else
		begin
			state_q  <= state_d;
			settle_q <= settle_d;
			// taken from the next state so the flag never lags the state register
			in_reset <= (state_d != hsp_pkg::HSP_ST_RUN); // [RULE10]
		end
	end

	// straps are caught after power-on release and after every chip reset release
	always_ff @(posedge sys_clk)
	begin
		if (!reset_n)
		begin
			smbus_mode_q <= hsp_pkg::RST_SMBUS_MODE;
			fixed_cnt_q  <= hsp_pkg::RST_FIXED_CNT;
			charge_en_q  <= hsp_pkg::RST_CHARGE_EN;
			gang_mode_q  <= hsp_pkg::RST_GANG_MODE;
		end
		else if (capture) // [RULE1]
		begin
			// pulled-up clock and data read high; anything else means rom mode
			smbus_mode_q <= clk_s & dat_s; // [RULE13]
			fixed_cnt_q  <= rom_sel_s; // [RULE8]
			charge_en_q  <= din_s; // [RULE9]
			gang_mode_q  <= gang_s; // [RULE11]
		end
	end

	// pin function mux; every enable is zero until run, so straps see no drive
	wire sel_o_d  = spi_run ? ~rom_access : general_io_a_out; // [RULE4]
	wire sel_oe_d = spi_run | (smb_run & general_io_a_en); // [RULE14]
	wire clk_o_d  = spi_run & rom_clk; // [RULE5]
	wire clk_oe_d = spi_run | (smb_run & mgmt_clock_pull_low); // [RULE5]
	wire dat_o_d  = spi_run & rom_mosi; // [RULE6]
	wire dat_oe_d = spi_run | (smb_run & mgmt_data_pull_low); // [RULE6]
	wire din_o_d  = smb_run & general_io_d_out; // [RULE7]
	wire din_oe_d = smb_run & general_io_d_en; // [RULE7]

	// registered pin stage keeps mode changes glitch free
	always_ff @(posedge sys_clk)
	begin
		if (!reset_n)
		begin
			rom_select_n_o    <= 1'b1;
			rom_select_n_oe   <= 1'b0;
			mgmt_bus_clock_o  <= 1'b0;
			mgmt_bus_clock_oe <= 1'b0;
			mgmt_bus_data_o   <= 1'b0;
			mgmt_bus_data_oe  <= 1'b0;
			rom_serial_in_o   <= 1'b0;
			rom_serial_in_oe  <= 1'b0;
		end
		else
		begin
			rom_select_n_o    <= sel_o_d;
			rom_select_n_oe   <= sel_oe_d;
			mgmt_bus_clock_o  <= clk_o_d;
			mgmt_bus_clock_oe <= clk_oe_d;
			mgmt_bus_data_o   <= dat_o_d;
			mgmt_bus_data_oe  <= dat_oe_d;
			rom_serial_in_o   <= din_o_d;
			rom_serial_in_oe  <= din_oe_d;
		end
	end

	// inputs back to the user side, already synchronised
	assign rom_miso         = din_s; // [RULE7]
	assign general_io_d_in  = din_s;
	assign general_io_a_in  = rom_sel_s;
	assign mgmt_clock_in    = clk_s;
	assign mgmt_data_in     = dat_s;
	assign smbus_mode       = smbus_mode_q;
	assign fixed_port_count = fixed_cnt_q;
	assign charging_enable  = charge_en_q;
	assign gang_mode        = gang_mode_q;

	// per-port power pins, idle in gang mode
	logic [hsp_pkg::PORT_COUNT-1:0] port_pin_s;
	logic [hsp_pkg::PORT_COUNT-1:0] port_o;
	logic [hsp_pkg::PORT_COUNT-1:0] port_oe;
	logic [hsp_pkg::PORT_COUNT-1:0] port_oc;
	logic                           gang_oc;

	assign port_pin_s = {sync_s[hsp_pkg::SB_PORT2], sync_s[hsp_pkg::SB_PORT1]};

	for (genvar i = 0; i < hsp_pkg::PORT_COUNT; i++)
	begin : g_port
		hsp_port_power u_port (
			.sys_clk     (sys_clk),
			.reset_n     (reset_n),
			.active      (run & ~gang_mode_q),
			.power_req   (port_power_req[i]),
			.oc_clear    (port_oc_clear[i]),
			.pin_in      (port_pin_s[i]),
			.pin_o       (port_o[i]),
			.pin_oe      (port_oe[i]),
			.overcurrent (port_oc[i])
		);
	end

	// one shared power pin serves all ports in gang mode
	hsp_port_power u_gang (
		.sys_clk     (sys_clk),
		.reset_n     (reset_n),
		.active      (run & gang_mode_q), // [RULE11]
		.power_req   (|port_power_req),
		.oc_clear    (|port_oc_clear),
		.pin_in      (gang_s),
		.pin_o       (shared_power_select_o),
		.pin_oe      (shared_power_select_oe),
		.overcurrent (gang_oc)
	);

	assign port1_power_ctl_oc_o  = port_o[0];
	assign port1_power_ctl_oc_oe = port_oe[0];
	assign port2_power_ctl_oc_o  = port_o[1];
	assign port2_power_ctl_oc_oe = port_oe[1];
	// a shared fault is reported on every port
	wire [hsp_pkg::PORT_COUNT-1:0] oc_report = gang_mode_q ? {hsp_pkg::PORT_COUNT{gang_oc}} : port_oc; // [RULE3]

	// fault status leaves through a flop, one cycle behind the sticky flags
	always_ff @(posedge sys_clk)
	begin
		if (!reset_n)
			port_overcurrent <= '0;
		else
			port_overcurrent <= oc_report; // [RULE11]
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);

	property p_strap_capture;
		capture |=> fixed_cnt_q == $past(rom_sel_s) && charge_en_q == $past(din_s) && run;
	endproperty
	a_strap_capture: assert property (p_strap_capture) else $error("straps not captured at release"); // [RULE1]

	property p_strap_hold;
		run && $past(run) |-> $stable(smbus_mode_q) && $stable(gang_mode_q) && $stable(fixed_cnt_q);
	endproperty
	a_strap_hold: assert property (p_strap_hold) else $error("strap value changed while running"); // [RULE1]

	property p_reset_mode;
		!chip_rst_n_s |=> in_reset [*2];
	endproperty
	a_reset_mode: assert property (p_reset_mode) else $error("left reset while chip reset held"); // [RULE10]

	property p_no_drive;
		!run |=> !rom_select_n_oe && !mgmt_bus_clock_oe && !mgmt_bus_data_oe && !rom_serial_in_oe;
	endproperty
	a_no_drive: assert property (p_no_drive) else $error("pin driven before straps captured"); // [RULE14]

	property p_rom_select;
		spi_run && rom_access |=> rom_select_n_oe && !rom_select_n_o;
	endproperty
	a_rom_select: assert property (p_rom_select) else $error("rom select not low during access"); // [RULE4]

	property p_clock_od;
		smb_run |=> !mgmt_bus_clock_o && !mgmt_bus_data_o;
	endproperty
	a_clock_od: assert property (p_clock_od) else $error("bus pins driven high in open-drain mode"); // [RULE5]

	property p_data_spi;
		spi_run |=> mgmt_bus_data_oe && mgmt_bus_data_o == $past(rom_mosi) && mgmt_bus_clock_o == $past(rom_clk);
	endproperty
	a_data_spi: assert property (p_data_spi) else $error("rom data or clock not on pin"); // [RULE6]

	property p_din_input;
		spi_run |=> !rom_serial_in_oe;
	endproperty
	a_din_input: assert property (p_din_input) else $error("rom data-in pin driven in rom mode"); // [RULE7]

	property p_mode_pick;
		capture |=> smbus_mode_q == ($past(clk_s) & $past(dat_s));
	endproperty
	a_mode_pick: assert property (p_mode_pick) else $error("serial mode not chosen from pull-ups"); // [RULE13]

	property p_gang_idle;
		run && gang_mode_q |=> !port1_power_ctl_oc_oe && !port2_power_ctl_oc_oe;
	endproperty
	a_gang_idle: assert property (p_gang_idle) else $error("per-port pin driven in gang mode"); // [RULE11]

	c_capture: cover property (capture);
	c_smbus:   cover property (smb_run && mgmt_data_pull_low);
	c_gang:    cover property (run && gang_mode_q && |port_power_req);
	c_rerun:   cover property (run ##1 !run ##[1:40] run);
endmodule

// [hw/hsp_pkg.sv]
package hsp_pkg;
	// reference and fabric clock rates
	localparam int SYS_CLK_MHZ      = 40;
	localparam int REF_CLK_MHZ      = 25;

	// strap settle time after reset release, a least time, rounded up
	localparam int STRAP_SETTLE_NS  = 500;
	localparam int STRAP_SETTLE_CYC = (STRAP_SETTLE_NS * SYS_CLK_MHZ + 999) / 1000;

	// overcurrent sense period (rounded down) and release window (rounded up)
	localparam int SENSE_PERIOD_NS  = 10000;
	localparam int SENSE_PERIOD_CYC = (SENSE_PERIOD_NS * SYS_CLK_MHZ) / 1000;
	localparam int SENSE_WIN_NS     = 200;
	localparam int SENSE_WIN_CYC    = (SENSE_WIN_NS * SYS_CLK_MHZ + 999) / 1000;
	localparam int CNT_W            = 9;

	localparam int PORT_COUNT       = 2;

	// synchroniser bit positions of the pin inputs
	localparam int SYNC_W           = 8;
	localparam int SB_CHIP_RST      = 0;
	localparam int SB_ROM_SEL       = 1;
	localparam int SB_MGMT_CLK      = 2;
	localparam int SB_MGMT_DAT      = 3;
	localparam int SB_ROM_DIN       = 4;
	localparam int SB_PORT1         = 5;
	localparam int SB_PORT2         = 6;
	localparam int SB_GANG          = 7;

	// reset values of captured straps
	localparam logic RST_SMBUS_MODE = 1'b0;
	localparam logic RST_FIXED_CNT  = 1'b0;
	localparam logic RST_CHARGE_EN  = 1'b0;
	localparam logic RST_GANG_MODE  = 1'b0;

	typedef enum logic [1:0] {
		HSP_ST_HOLD,
		HSP_ST_SETTLE,
		HSP_ST_RUN
	} hsp_state_t;
endpackage

// [hw/hsp_port_power.sv]
`timescale 1ns/1ps
// one power enable pin that doubles as overcurrent sense
module hsp_port_power (
	input  wire logic sys_clk,
	input  wire logic reset_n,
	input  wire logic active,
	input  wire logic power_req,
	input  wire logic oc_clear,
	input  wire logic pin_in,
	output logic      pin_o,
	output logic      pin_oe,
	output logic      overcurrent
);
	localparam logic [hsp_pkg::CNT_W-1:0] LAST = hsp_pkg::CNT_W'(hsp_pkg::SENSE_PERIOD_CYC - 1);
	localparam logic [hsp_pkg::CNT_W-1:0] WIN0 =
		hsp_pkg::CNT_W'(hsp_pkg::SENSE_PERIOD_CYC - hsp_pkg::SENSE_WIN_CYC);

	logic [hsp_pkg::CNT_W-1:0] cnt_q;
	logic [hsp_pkg::CNT_W-1:0] cnt_d;
	logic                      oc_d;
	wire                       power_on = active & power_req & ~overcurrent;
	wire                       sensing  = power_on & (cnt_q >= WIN0);
	// pin stays released for the whole window, so the synchronised level is settled by the end
	wire                       oc_evt   = sensing & (cnt_q == LAST) & ~pin_in; // [RULE3]

	assign cnt_d = (!power_on || cnt_q == LAST) ? '0 : cnt_q + 1'b1;
	assign oc_d  = (overcurrent & ~oc_clear) | oc_evt; // set wins over clear

	// drive high for on, low for off while active; release to sense or when inactive
	always_ff @(posedge sys_clk)
	begin
		if (!reset_n)
		begin
			cnt_q       <= '0;
			pin_o       <= 1'b0;
			pin_oe      <= 1'b0;
			overcurrent <= 1'b0;
		end
		else
		begin
			cnt_q       <= cnt_d;
			pin_o       <= power_on; // [RULE2]
			pin_oe      <= active & ~sensing; // [RULE2]
			overcurrent <= oc_d;
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);

	property p_port_off_low;
		active && !power_req |=> pin_oe && !pin_o;
	endproperty
	a_port_off_low: assert property (p_port_off_low) else $error("port pin not driven low when off"); // [RULE2]

	property p_oc_sticky;
		oc_evt |=> overcurrent ##1 (overcurrent || $past(oc_clear));
	endproperty
	a_oc_sticky: assert property (p_oc_sticky) else $error("overcurrent event not latched"); // [RULE3]

	c_oc_seen: cover property (oc_evt);
endmodule

// [hw/hsp_sync.sv]
`timescale 1ns/1ps
// two-stage synchroniser for pin inputs; stage one feeds only stage two
module hsp_sync #(
	parameter int W = 1
) (
	input  wire logic         sys_clk,
	input  wire logic         reset_n,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);
	logic [W-1:0] meta_q;

	// plain flop pair, constant reset value
	always_ff @(posedge sys_clk)
	begin
		if (!reset_n)
		begin
			meta_q   <= '0;
			sync_out <= '0;
		end
		else
		begin
			meta_q   <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule

// [verification/hsp_board_model.sv]
`timescale 1ns/1ps
// board side of the pins: strap resistors, current monitors, serial rom
// pin order: 0 select, 1 clock, 2 data, 3 data-in, 4 port1, 5 port2, 6 shared
module hsp_board_model #(
	parameter logic [7:0] ROM_WORD = 8'hA5
) (
	input  wire logic       sys_clk,
	input  wire logic       pull_ups,
	input  wire logic       fixed_lvl,
	input  wire logic       charge_lvl,
	input  wire logic       gang_lvl,
	input  wire logic [1:0] fault,
	input  wire logic [7:0] pin_o,
	input  wire logic [7:0] pin_oe,
	output logic      [7:0] pin_i
);
	logic       flt_q      = 1'b0;
	logic       clk_prev_q = 1'b0;
	logic [2:0] idx_q      = 3'h0;
	wire        rom_sel    = pin_oe[0] && !pin_o[0];

	// rom shifts one bit per rising pin clock, restarts when deselected
	always_ff @(posedge sys_clk)
	begin
		flt_q      <= ~flt_q;
		clk_prev_q <= pin_i[1];
		if (!rom_sel)
			idx_q <= 3'h0;
		else if (pin_i[1] && !clk_prev_q)
			idx_q <= idx_q + 3'h1;
	end

	// driver wins; lines without pulls toggle in opposite phase, never both high
	assign pin_i[0] = pin_oe[0] ? pin_o[0] : fixed_lvl;
	assign pin_i[1] = pin_oe[1] ? pin_o[1] : (pull_ups ? 1'b1 : flt_q);
	assign pin_i[2] = pin_oe[2] ? pin_o[2] : (pull_ups ? 1'b1 : ~flt_q);
	assign pin_i[3] = pin_oe[3] ? pin_o[3] : (rom_sel ? ROM_WORD[3'h7 - idx_q] : charge_lvl);
	assign pin_i[4] = pin_oe[4] ? pin_o[4] : ~fault[0];
	assign pin_i[5] = pin_oe[5] ? pin_o[5] : ~fault[1];
	// shared monitor pulls the gang pin low on a fault
	assign pin_i[6] = pin_oe[6] ? pin_o[6] : (gang_lvl & ~fault[0]);
	assign pin_i[7] = 1'b0;
endmodule

// [verification/tb.sv]
`timescale 1ns/1ps
// strap capture, pin muxing and port power checks
module tb;
	localparam logic [7:0] ROM_WORD = 8'hA5;
	logic       sys_clk = 1'b0;
	logic       reset_n = 1'b0;
	logic       chip_reset_n = 1'b1;
	logic       rom_access = 1'b0;
	logic       rom_clk = 1'b0;
	logic       rom_mosi = 1'b0;
	logic       clk_low = 1'b0;
	logic       dat_low = 1'b0;
	logic       gpa_out = 1'b0;
	logic       gpa_en = 1'b0;
	logic       gpd_out = 1'b0;
	logic       gpd_en = 1'b0;
	logic [1:0] power_req = 2'h0;
	logic [1:0] oc_clear = 2'h0;
	logic       pull_ups = 1'b1;
	logic       fixed_lvl = 1'b1;
	logic       charge_lvl = 1'b1;
	logic       gang_lvl = 1'b0;
	logic [1:0] fault = 2'h0;
	logic [7:0] pin_o;
	logic [7:0] pin_oe;
	logic [7:0] pin_i;
	logic [1:0] overcurrent;
	logic       rom_miso, clk_in, dat_in, gpa_in, gpd_in;
	logic       in_reset, smbus_mode, fixed_cnt, charge_en, gang_mode;
	int         fail_count = 0;
	int         compares = 0;
	int         cycles = 0;

	assign pin_o[7]  = 1'b0;
	assign pin_oe[7] = 1'b0;

	hsp_pin_ctl dut (.sys_clk(sys_clk), .reset_n(reset_n), .chip_reset_n(chip_reset_n),
		.rom_select_n_i(pin_i[0]), .rom_select_n_o(pin_o[0]), .rom_select_n_oe(pin_oe[0]),
		.mgmt_bus_clock_i(pin_i[1]), .mgmt_bus_clock_o(pin_o[1]), .mgmt_bus_clock_oe(pin_oe[1]),
		.mgmt_bus_data_i(pin_i[2]), .mgmt_bus_data_o(pin_o[2]), .mgmt_bus_data_oe(pin_oe[2]),
		.rom_serial_in_i(pin_i[3]), .rom_serial_in_o(pin_o[3]), .rom_serial_in_oe(pin_oe[3]),
		.port1_power_ctl_oc_i(pin_i[4]), .port1_power_ctl_oc_o(pin_o[4]), .port1_power_ctl_oc_oe(pin_oe[4]),
		.port2_power_ctl_oc_i(pin_i[5]), .port2_power_ctl_oc_o(pin_o[5]), .port2_power_ctl_oc_oe(pin_oe[5]),
		.shared_power_select_i(pin_i[6]), .shared_power_select_o(pin_o[6]), .shared_power_select_oe(pin_oe[6]),
		.rom_access(rom_access), .rom_clk(rom_clk), .rom_mosi(rom_mosi), .rom_miso(rom_miso),
		.mgmt_clock_pull_low(clk_low), .mgmt_data_pull_low(dat_low), .mgmt_clock_in(clk_in),
		.mgmt_data_in(dat_in), .general_io_a_out(gpa_out), .general_io_a_en(gpa_en),
		.general_io_a_in(gpa_in), .general_io_d_out(gpd_out), .general_io_d_en(gpd_en),
		.general_io_d_in(gpd_in), .port_power_req(power_req), .port_oc_clear(oc_clear),
		.port_overcurrent(overcurrent), .in_reset(in_reset), .smbus_mode(smbus_mode),
		.fixed_port_count(fixed_cnt), .charging_enable(charge_en), .gang_mode(gang_mode));

	hsp_board_model #(.ROM_WORD(ROM_WORD)) board (.sys_clk(sys_clk), .pull_ups(pull_ups),
		.fixed_lvl(fixed_lvl), .charge_lvl(charge_lvl), .gang_lvl(gang_lvl), .fault(fault),
		.pin_o(pin_o), .pin_oe(pin_oe), .pin_i(pin_i));

	// 40 MHz clock
	always #12.5 sys_clk = ~sys_clk;

	// hang guard: whole run takes about a thousand cycles
	always @(posedge sys_clk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			fail_count++;
			tally_and_finish();
		end
	end

	task automatic tally_and_finish();
		if (fail_count == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// sample just after the edge so registered outputs have settled
	task automatic step(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask

	task automatic check_straps(input logic [3:0] exp);
		check({4'h0, smbus_mode, fixed_cnt, charge_en, gang_mode}, {4'h0, exp});
	endtask

	// pins stay released until straps are in; bounded wait for run state
	task automatic wait_run();
		int n;
		n = 0;
		while (in_reset !== 1'b0 && n < 40)
		begin
			check(pin_oe, 8'h00);
			step(1);
			n++;
		end
		check(8'(n >= hsp_pkg::STRAP_SETTLE_CYC && n <= hsp_pkg::STRAP_SETTLE_CYC + 6), 8'h01);
	endtask

	task automatic chip_reset();
		@(posedge sys_clk);
		chip_reset_n <= 1'b0;
		step(4);
		check({7'h0, in_reset}, 8'h01);
		check(pin_oe, 8'h00);
		step(10);
		check({7'h0, in_reset}, 8'h01);
		@(posedge sys_clk);
		chip_reset_n <= 1'b1;
		step(1);
		wait_run();
	endtask

	initial
	begin
		repeat (7) @(posedge sys_clk);
		#1;
		check({7'h0, in_reset}, 8'h01);
		check(pin_oe, 8'h00);
		check_straps(4'h0);
		@(posedge sys_clk);
		reset_n <= 1'b1;
		step(1);
		wait_run();
		check_straps(4'b1110);

		// bus mode: open-drain clock and data, gpio on select and data-in
		@(posedge sys_clk);
		{gpa_en, gpd_en, rom_access} <= 3'b111;
		for (int k = 0; k < 2; k++)
		begin
			@(posedge sys_clk);
			{clk_low, dat_low} <= k[0] ? 2'b01 : 2'b10;
			gpa_out <= k[0];
			gpd_out <= !k[0];
			step(4);
			check({pin_o[3:0], pin_oe[3:0]}, k[0] ? 8'h1D : 8'h8B);
			check({4'h0, clk_in, dat_in, gpa_in, gpd_in}, k[0] ? 8'h0A : 8'h05);
		end

		// port power on, monitor fault on port 1 only
		@(posedge sys_clk);
		{rom_access, clk_low, dat_low} <= 3'b000;
		power_req <= 2'b11;
		fault <= 2'b01;
		step(2);
		check({4'h0, pin_o[5:4], pin_oe[5:4]}, 8'h0F);
		for (int n = 0; n < 420 && overcurrent[0] !== 1'b1; n++)
			step(1);
		step(1);
		check({6'h0, overcurrent}, 8'h01);
		check({6'h0, pin_o[4], pin_oe[4]}, 8'h01);
		@(posedge sys_clk);
		{power_req, oc_clear, fault} <= 6'b000100;
		step(3);
		check({2'h0, overcurrent, pin_o[5:4], pin_oe[5:4]}, 8'h03);

		// rom mode with gang strap high, recaptured on chip reset release
		@(posedge sys_clk);
		oc_clear <= 2'b00;
		{pull_ups, fixed_lvl, charge_lvl, gang_lvl} <= 4'b0001;
		chip_reset();
		check_straps(4'b0001);
		@(posedge sys_clk);
		{rom_access, rom_mosi} <= 2'b11;
		step(4);
		check({1'b0, pin_o[2:0], pin_oe[3:0]}, 8'h47);
		check({7'h0, rom_miso}, {7'h0, ROM_WORD[7]});
		@(posedge sys_clk);
		rom_clk <= 1'b1;
		step(5);
		check({7'h0, pin_o[1]}, 8'h01);
		check({7'h0, rom_miso}, {7'h0, ROM_WORD[6]});
		@(posedge sys_clk);
		{rom_access, rom_clk} <= 2'b00;
		power_req <= 2'b10;
		step(3);
		check({6'h0, pin_o[0], pin_oe[0]}, 8'h03);
		check({4'h0, pin_o[6], pin_oe[6], pin_oe[5:4]}, 8'h0C);

		// shared monitor trips: fault shows on both ports, the port 2 clear drops it
		@(posedge sys_clk);
		fault <= 2'b01;
		for (int n = 0; n < 420 && overcurrent[1] !== 1'b1; n++)
			step(1);
		step(1);
		check({4'h0, overcurrent, pin_o[6], pin_oe[6]}, 8'h0D);
		@(posedge sys_clk);
		{oc_clear, fault} <= 4'b1000;
		step(3);
		check({6'h0, overcurrent}, 8'h00);
		tally_and_finish();
	end
endmodule
